//--- cpod_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpod_core_model (
  input wire logic clk, acc_we,
  input wire logic [3:0] ld_val, acc_wdata,
  output logic [3:0] acc_in
);
  // write-back wins over the bench load, as in the core
  always_ff @(posedge clk) acc_in <= acc_we ? acc_wdata : ld_val;
endmodule : cpod_core_model
`default_nettype wire

//--- cpod_dec_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cpod_dec_if;
  import cpod_pkg::*;
  logic [9:0] word;
  logic valid;
  cpod_op_e op;
  logic [1:0] imm;

  modport dec (input word, input valid, output op, output imm);
  modport core (output word, output valid, input op, input imm);
endinterface : cpod_dec_if

`default_nettype wire

//--- cpod_decoder.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpod_defines.svh"

module cpod_decoder
  import cpod_pkg::*;
(
  cpod_dec_if.dec bus
);

  always_comb
  begin
    bus.imm = bus.word[1:0];
    if (!bus.valid)
    begin
      bus.op = CPOD_OP_NONE;
    end
    else
    begin
      case (bus.word)
        `CPOD_IDLE_CODE: bus.op = CPOD_OP_IDLE;
        `CPOD_PORT0_CODE: bus.op = CPOD_OP_OUT0;
        `CPOD_PORT1_CODE: bus.op = CPOD_OP_OUT1;
        `CPOD_PORT2_CODE: bus.op = CPOD_OP_OUT2;
        `CPOD_PORT3_CODE: bus.op = CPOD_OP_OUT3;
        `CPOD_OR_CODE: bus.op = CPOD_OP_OR;
        default:
        begin
          if ((bus.word & `CPOD_FSEL_MASK) == `CPOD_FSEL_CODE)
          begin
            bus.op = CPOD_OP_FSEL;
          end
          else
          begin
            bus.op = CPOD_OP_NONE;
          end
        end
      endcase
    end
  end

endmodule : cpod_decoder

`default_nettype wire

//--- cpod_defines.svh
`ifndef CPOD_DEFINES_SVH
`define CPOD_DEFINES_SVH

// instruction encodings, 10-bit words
`define CPOD_IDLE_CODE 10'h000
`define CPOD_FSEL_MASK 10'h3FC
`define CPOD_FSEL_CODE 10'h048
`define CPOD_PORT0_CODE 10'h220
`define CPOD_PORT1_CODE 10'h221
`define CPOD_PORT2_CODE 10'h222
`define CPOD_PORT3_CODE 10'h223
`define CPOD_OR_CODE 10'h019

// reset values
`define CPOD_ACC_RST 4'h0
`define CPOD_FILE_RST 2'h0
`define CPOD_PORT4_RST 4'h0
`define CPOD_PORT2_RST 2'h0

`endif

//--- cpod_pkg.sv
package cpod_pkg;

  typedef enum logic [2:0] {
    CPOD_OP_NONE = 3'b000,
    CPOD_OP_FSEL = 3'b001,
    CPOD_OP_IDLE = 3'b010,
    CPOD_OP_OUT0 = 3'b011,
    CPOD_OP_OUT1 = 3'b100,
    CPOD_OP_OUT2 = 3'b101,
    CPOD_OP_OUT3 = 3'b110,
    CPOD_OP_OR = 3'b111
  } cpod_op_e;

endpackage : cpod_pkg

//--- cpod_port_ops.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpod_defines.svh"


module cpod_port_ops
  import cpod_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] instr_word,
  input wire logic instr_valid,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] mem_rdata,
  output logic pc_inc,
  output logic acc_we,
  output logic [3:0] acc_wdata,
  output logic file_select_we,
  output logic skip_next,
  output logic carry_we,
  output logic [1:0] file_select,
  output logic [3:0] output_port_zero,
  output logic [3:0] output_port_one,
  output logic [1:0] output_port_two,
  output logic [1:0] output_port_three
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  cpod_dec_if dec_bus ();
  cpod_op_e op;

  assign dec_bus.word = instr_word;
  assign dec_bus.valid = instr_valid;
  assign op = dec_bus.op;

  cpod_decoder u_dec (
    .bus(dec_bus)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0] file_reg, file_next;
  logic [3:0] port0_reg, port0_next;
  logic [3:0] port1_reg, port1_next;
  logic [1:0] port2_reg, port2_next;
  logic [1:0] port3_reg, port3_next;
  logic [3:0] acc_reg, acc_next;
  logic acc_we_reg, acc_we_next;
  logic fs_we_reg, fs_we_next;

  always_comb
  begin
    file_next = file_reg;
    port0_next = port0_reg;
    port1_next = port1_reg;
    port2_next = port2_reg;
    port3_next = port3_reg;
    acc_next = acc_reg;
    acc_we_next = 1'b0;
    fs_we_next = 1'b0;
    case (op)
      CPOD_OP_FSEL:
      begin
        file_next = dec_bus.imm;
        fs_we_next = 1'b1;
      end
      CPOD_OP_IDLE:
      begin
        // nothing but the pc step
        file_next = file_reg;
      end
      CPOD_OP_OUT0:
      begin
        port0_next = acc_in;
      end
      CPOD_OP_OUT1:
      begin
        port1_next = acc_in;
      end
      CPOD_OP_OUT2:
      begin
        port2_next = acc_in[1:0];
      end
      CPOD_OP_OUT3:
      begin
        port3_next = acc_in[1:0];
      end
      CPOD_OP_OR:
      begin
        // single cycle result handed back to the core
        acc_next = acc_in | mem_rdata;
        acc_we_next = 1'b1;
      end
      default:
      begin
        acc_we_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      file_reg <= `CPOD_FILE_RST;
      port0_reg <= `CPOD_PORT4_RST;
      port1_reg <= `CPOD_PORT4_RST;
      port2_reg <= `CPOD_PORT2_RST;
      port3_reg <= `CPOD_PORT2_RST;
      acc_reg <= `CPOD_ACC_RST;
      acc_we_reg <= 1'b0;
      fs_we_reg <= 1'b0;
    end
    else
    begin
      file_reg <= file_next;
      port0_reg <= port0_next;
      port1_reg <= port1_next;
      port2_reg <= port2_next;
      port3_reg <= port3_next;
      acc_reg <= acc_next;
      acc_we_reg <= acc_we_next;
      fs_we_reg <= fs_we_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every decoded op is one word, so the pc steps once
  assign pc_inc = (op != CPOD_OP_NONE);
  // none of these ops touches carry or skips
  assign carry_we = 1'b0;
  assign skip_next = 1'b0;
  assign acc_we = acc_we_reg;
  assign acc_wdata = acc_reg;
  assign file_select_we = fs_we_reg;
  assign file_select = file_reg;
  assign output_port_zero = port0_reg;
  assign output_port_one = port1_reg;
  assign output_port_two = port2_reg;
  assign output_port_three = port3_reg;

endmodule : cpod_port_ops

`default_nettype wire

//--- cpod_port_ops_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cpod_port_ops_chk (
  input wire logic clk, rst, instr_valid, pc_inc, acc_we,
  input wire logic [9:0] instr_word,
  input wire logic [3:0] acc_in, mem_rdata, acc_wdata, output_port_zero,
  input wire logic [3:0] output_port_one,
  input wire logic [1:0] file_select, output_port_two, output_port_three
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire [9:0] op = instr_valid ? instr_word : 10'h3FF;
  a_fsel_load: assert property (
    op[9:2] == 8'h12 |=> file_select == $past(instr_word[1:0]))
    else $error("file select load wrong");
  a_idle_quiet: assert property (
    op == 10'h000 |-> pc_inc ##1 !acc_we && $stable(output_port_one))
    else $error("idle op changed state");
  a_port0_copy: assert property (
    op == 10'h220 |-> pc_inc ##1 output_port_zero == $past(acc_in))
    else $error("port zero copy wrong");
  a_port1_copy: assert property (
    op == 10'h221 |=> output_port_one == $past(acc_in))
    else $error("port one copy wrong");
  a_port2_low: assert property (
    op == 10'h222 |=> output_port_two == $past(acc_in[1:0]))
    else $error("port two copy wrong");
  a_port3_low: assert property (
    op == 10'h223 |=> output_port_three == $past(acc_in[1:0]))
    else $error("port three copy wrong");
  a_or_strobe: assert property (
    op == 10'h019 |-> pc_inc ##1 acc_we) else $error("or strobe missing");
  a_or_result: assert property (
    op == 10'h019 |=> acc_wdata == ($past(acc_in) | $past(mem_rdata)))
    else $error("or");
  cover property (acc_we);
  cover property (op == 10'h222);
  cover property (op == 10'h000);
endmodule : cpod_port_ops_chk
bind cpod_port_ops cpod_port_ops_chk i_chk (.*);
`default_nettype wire

//--- test_cpu_port_output_ops_decode.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_port_output_ops_decode;
  logic clk = 1'h0, rst = 1'h1, instr_valid = 1'h0, acc_we;
  logic pc_inc, file_select_we, skip_next, carry_we;
  logic [9:0] instr_word = 10'h000;
  logic [3:0] ld_val = 4'h0, mem_rdata = 4'h5, acc_in, acc_wdata;
  logic [3:0] output_port_zero, output_port_one;
  logic [1:0] file_select, output_port_two, output_port_three;
  logic [14:0] got;
  logic [31:0] rows [8] = '{32'h220C6000, 32'h22156280, 32'h222E62C0,
    32'h223762D8, 32'h04B062DE, 32'h000F62DE, 32'h019A62DF, 32'h3FFF62DE};
  int fails = 0, checks_done = 0;
  always #20 clk = ~clk;
  cpod_port_ops i_dut (.*);
  cpod_core_model i_core (.*);
  task automatic check(input string what, input logic [14:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic print_verdict;
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst = 1'h0;
    foreach (rows[i])
    begin
      ld_val = rows[i][19:16];
      @(posedge clk) #1 {instr_valid, instr_word} = {1'h1, rows[i][29:20]};
      @(posedge clk) #1 instr_valid = 1'h0;
      got = {output_port_zero, output_port_one, output_port_two,
        output_port_three, file_select, acc_we};
      check("outputs", got, rows[i][14:0]);
    end
    ld_val = 4'h3;
    mem_rdata = 4'hC;
    @(posedge clk) #1 {instr_valid, instr_word} = {1'h1, 10'h019};
    #4 check("pc_inc", 15'(pc_inc), 15'h0001);
    @(posedge clk) #1 instr_valid = 1'h0;
    check("acc_wdata", 15'(acc_wdata), 15'h000F);
    check("acc_we", 15'(acc_we), 15'h0001);
    check("flags", 15'({carry_we, skip_next}), 15'h0000);
    @(posedge clk) #1 {instr_valid, instr_word} = {1'h1, 10'h049};
    @(posedge clk) #1 instr_word = 10'h04A;
    check("file_select", 15'(file_select), 15'h0001);
    check("file_select_we", 15'(file_select_we), 15'h0001);
    @(posedge clk) #1 instr_word = 10'h3FF;
    check("file_select", 15'(file_select), 15'h0002);
    #4 check("pc_inc refused", 15'(pc_inc), 15'h0000);
    @(posedge clk) #1 instr_valid = 1'h0;
    check("file_select_we", 15'(file_select_we), 15'h0000);
    check("file_select", 15'(file_select), 15'h0002);
    @(posedge clk) #1 rst = 1'h1;
    @(posedge clk) #1 {rst, instr_valid, instr_word} = {1'h0, 1'h1, 10'h220};
    check("after reset", {output_port_zero, output_port_one, output_port_two,
      output_port_three, file_select, acc_we}, 15'h0000);
    check("acc_wdata reset", 15'(acc_wdata), 15'h0000);
    @(posedge clk) #1 instr_valid = 1'h0;
    check("port zero", 15'(output_port_zero), 15'h0003);
    print_verdict;
  end
endmodule : test_cpu_port_output_ops_decode
`default_nettype wire
